//--- pkg/scrb_pkg.sv
/*
  Constants, enumerations and carrier structs of the sensor configuration register bank.
  Assumes a single 200 MHz clock and a host that reaches the bank as 16-bit words.
*/
package scrb_pkg;
    // word offsets as the host addresses them
    localparam logic [7:0]  SCRB_OFS_STATUS     = 8'h11;
    localparam logic [7:0]  SCRB_OFS_FRONT_END  = 8'h23;
    localparam logic [7:0]  SCRB_OFS_PAT_SETUP  = 8'h24;
    localparam logic [7:0]  SCRB_OFS_PAT_CHOICE = 8'h25;
    localparam logic [7:0]  SCRB_OFS_AT_SETUP   = 8'h26;
    localparam logic [7:0]  SCRB_OFS_AT_SCALE   = 8'h28;
    localparam logic [7:0]  SCRB_OFS_AT_OFFSET  = 8'h29;
    localparam logic [7:0]  SCRB_OFS_PROX       = 8'h40;
    localparam logic [7:0]  SCRB_OFS_CONTACT    = 8'h41;
    localparam logic [7:0]  SCRB_OFS_SYS_CMD    = 8'h70;
    // field positions
    localparam int          SCRB_BIT_DEAD_TIME  = 6;
    localparam int          SCRB_BIT_RESET_EVT  = 7;
    localparam int          SCRB_BIT_RESEED     = 3;
    localparam int          SCRB_BIT_RETUNE     = 2;
    localparam int          SCRB_BIT_SOFT_RST   = 1;
    localparam int          SCRB_BIT_ACK_RST    = 0;
    // reserved bit of the offset word always reads zero
    localparam logic [15:0] SCRB_OFFSET_MASK    = 16'hF7FF;
    // reset values
    localparam logic [15:0] SCRB_RST_FRONT_END  = 16'h018B;
    localparam logic [15:0] SCRB_RST_PAT_SETUP  = 16'h0B00;
    localparam logic [15:0] SCRB_RST_PAT_CHOICE = 16'h0000;
    localparam logic [15:0] SCRB_RST_AT_SETUP   = 16'h0004;
    localparam logic [15:0] SCRB_RST_AT_SCALE   = 16'h0000;
    localparam logic [15:0] SCRB_RST_AT_OFFSET  = 16'h0000;
    localparam logic [15:0] SCRB_RST_PROX       = 16'h0000;
    localparam logic [15:0] SCRB_RST_CONTACT    = 16'h0000;
    localparam logic [7:0]  SCRB_RST_SYS_MODE   = 8'h00;
    localparam int          SCRB_PROX_SHIFT     = 8;

    typedef enum logic [3:0] {
        SCRB_IDLE_FLOAT = 4'h0,
        SCRB_IDLE_BIAS  = 4'h5,
        SCRB_IDLE_GND   = 4'hA,
        SCRB_IDLE_SUPPLY = 4'hF
    } scrb_idle_e;

    typedef enum logic [2:0] {
        SCRB_AT_OFF       = 3'h0,
        SCRB_AT_COMP_ONLY = 3'h1,
        SCRB_AT_FROM_COMP = 3'h2,
        SCRB_AT_FROM_FINE = 3'h3,
        SCRB_AT_FULL      = 3'h4
    } scrb_at_mode_e;

    typedef enum logic [1:0] {
        SCRB_IF_STANDALONE = 2'h0,
        SCRB_IF_STREAM     = 2'h1,
        SCRB_IF_RESERVED   = 2'h2,
        SCRB_IF_EVENTS     = 2'h3
    } scrb_iface_e;

    typedef enum logic [1:0] {
        SCRB_PWR_NORMAL = 2'h0,
        SCRB_PWR_ULP    = 2'h1,
        SCRB_PWR_AUTO   = 2'h2,
        SCRB_PWR_BAD    = 2'h3
    } scrb_power_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } scrb_req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] scalers;
        logic [15:0] offset;
    } scrb_tune_s;

    typedef struct packed {
        logic          dead_time_en;
        scrb_idle_e    idle_state;
        scrb_at_mode_e at_mode;
        logic [3:0]    exit_debounce;
        logic [3:0]    enter_debounce;
        logic [7:0]    contact_hyst;
        logic [7:0]    contact_thr;
        scrb_iface_e   iface;
        scrb_power_e   power;
    } scrb_cfg_s;

    typedef struct packed {
        logic reseed;
        logic retune_trigger;
        logic soft_reset;
    } scrb_trig_s;
endpackage

//--- src/scrb_bank.sv
/*
  Configuration and control register bank of a single-channel proximity/touch sensor.
  Assumes the host transport delivers one 16-bit word request per cycle, synchronous to
  clock_in, and that the tuning engine and sensing core consume the decoded fields.
*/
`timescale 1ns/1ps
// Function
// RQ1 - front-end bit 6 set enables drive dead time, cleared disables it
// RQ2 - host writes fixed values into the front-end reserved fields
// RQ3 - host keeps the calibration capacitor select bit 11 cleared
// RQ4 - pattern setup bits 3-0 choose idle electrode state: float, bias, ground, supply
// RQ5 - host programs waveform pattern fields to 0 and 0xB
// RQ6 - host writes zero into the pattern select byte
// RQ7 - autotune mode bits 2-0 decode five modes from disabled to full
// RQ8 - device computes scalers and offset itself; those words are debug only
// RQ9 - proximity bits 15-12 hold exit debounce, zero disables it
// RQ10 - proximity bits 11-8 hold entry debounce, zero disables it
// RQ11 - effective proximity threshold is field times long-term average over 256
// RQ12 - contact upper byte holds the touch release hysteresis
// RQ13 - contact lower byte holds the touch detection threshold
// RQ14 - command bits 7-6 select interface; reserved code 10 never takes effect
// RQ15 - command bits 5-4 select normal, ultra low or automatic power mode
// RQ16 - writing one to bits 3-0 triggers reseed, retune, soft reset, acknowledge
// RQ17 - status bit 7 reads one after a reset event, zero otherwise
// RQ18 - acknowledge clears the reset flag; trigger bits self-clear when accepted
// RQ19 - every register is one 16-bit word; reads return held or computed value
module scrb_bank (
    input  wire logic               clock_in,
    input  wire logic               srst_in,
    input  wire scrb_pkg::scrb_req_s req_in,
    input  wire scrb_pkg::scrb_tune_s tune_in,
    input  wire logic [15:0]        long_term_average_in,
    output logic [15:0]             rdata_out,
    output logic                    rvalid_out,
    output scrb_pkg::scrb_cfg_s     cfg_out,
    output scrb_pkg::scrb_trig_s    trig_out,
    output logic [15:0]             prox_thr_eff_out,
    output logic                    reset_event_out
);
    logic [15:0] front_r, front_nxt;
    logic [15:0] pat_setup_r, pat_setup_nxt;
    logic [15:0] pat_choice_r, pat_choice_nxt;
    logic [15:0] at_setup_r, at_setup_nxt;
    logic [15:0] at_scale_r, at_scale_nxt;
    logic [15:0] at_offset_r, at_offset_nxt;
    logic [15:0] prox_r, prox_nxt;
    logic [15:0] contact_r, contact_nxt;
    logic [1:0]  iface_r, iface_nxt;
    logic [1:0]  power_r, power_nxt;
    logic        reset_evt_r, reset_evt_nxt;
    logic [2:0]  trig_r, trig_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [15:0] prox_eff_r, prox_eff_nxt;
    logic [23:0] prox_product;
    logic        wr_cmd;
    logic [15:0] rd_mux;

    assign wr_cmd = req_in.wr && (req_in.addr == scrb_pkg::SCRB_OFS_SYS_CMD);

    // register writes; the host is trusted to honour the fixed reserved patterns
    always_comb begin
        front_nxt      = front_r;
        pat_setup_nxt  = pat_setup_r;
        pat_choice_nxt = pat_choice_r;
        at_setup_nxt   = at_setup_r;
        at_scale_nxt   = at_scale_r;
        at_offset_nxt  = at_offset_r;
        prox_nxt       = prox_r;
        contact_nxt    = contact_r;
        if (req_in.wr) begin
            unique case (req_in.addr)
                scrb_pkg::SCRB_OFS_FRONT_END:  front_nxt      = req_in.wdata;
                scrb_pkg::SCRB_OFS_PAT_SETUP:  pat_setup_nxt  = req_in.wdata;
                scrb_pkg::SCRB_OFS_PAT_CHOICE: pat_choice_nxt = req_in.wdata;
                scrb_pkg::SCRB_OFS_AT_SETUP:   at_setup_nxt   = req_in.wdata;
                scrb_pkg::SCRB_OFS_AT_SCALE:   at_scale_nxt   = req_in.wdata;
                scrb_pkg::SCRB_OFS_AT_OFFSET:  at_offset_nxt  = req_in.wdata
                                                                & scrb_pkg::SCRB_OFFSET_MASK;
                scrb_pkg::SCRB_OFS_PROX:       prox_nxt       = req_in.wdata; // RQ9 RQ10
                scrb_pkg::SCRB_OFS_CONTACT:    contact_nxt    = req_in.wdata; // RQ12 RQ13
                default: begin
                end
            endcase
        end
        // computed tuning results override a same-cycle debug write
        if (tune_in.valid) begin
            at_scale_nxt  = tune_in.scalers; // RQ8
            at_offset_nxt = tune_in.offset & scrb_pkg::SCRB_OFFSET_MASK; // RQ8
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            front_r      <= scrb_pkg::SCRB_RST_FRONT_END;
            pat_setup_r  <= scrb_pkg::SCRB_RST_PAT_SETUP;
            pat_choice_r <= scrb_pkg::SCRB_RST_PAT_CHOICE;
            at_setup_r   <= scrb_pkg::SCRB_RST_AT_SETUP;
            at_scale_r   <= scrb_pkg::SCRB_RST_AT_SCALE;
            at_offset_r  <= scrb_pkg::SCRB_RST_AT_OFFSET;
            prox_r       <= scrb_pkg::SCRB_RST_PROX;
            contact_r    <= scrb_pkg::SCRB_RST_CONTACT;
        end else begin
            front_r      <= front_nxt;
            pat_setup_r  <= pat_setup_nxt;
            pat_choice_r <= pat_choice_nxt;
            at_setup_r   <= at_setup_nxt;
            at_scale_r   <= at_scale_nxt;
            at_offset_r  <= at_offset_nxt;
            prox_r       <= prox_nxt;
            contact_r    <= contact_nxt;
        end
    end

    // system command: mode fields are held, trigger bits only pulse
    always_comb begin
        iface_nxt     = iface_r;
        power_nxt     = power_r;
        trig_nxt      = 3'h0; // RQ18
        reset_evt_nxt = reset_evt_r;
        if (wr_cmd) begin
            // a reserved code would leave the pins in an undefined role, so it is dropped
            if (req_in.wdata[7:6] != scrb_pkg::SCRB_IF_RESERVED) begin
                iface_nxt = req_in.wdata[7:6]; // RQ14
            end
            if (req_in.wdata[5:4] != scrb_pkg::SCRB_PWR_BAD) begin
                power_nxt = req_in.wdata[5:4]; // RQ15
            end
            trig_nxt = {req_in.wdata[scrb_pkg::SCRB_BIT_RESEED],
                        req_in.wdata[scrb_pkg::SCRB_BIT_RETUNE],
                        req_in.wdata[scrb_pkg::SCRB_BIT_SOFT_RST]}; // RQ16
            if (req_in.wdata[scrb_pkg::SCRB_BIT_ACK_RST]) begin
                reset_evt_nxt = 1'b0; // RQ18
            end
        end
        // a soft reset in flight sets the flag even against an acknowledge
        if (trig_r[0]) begin
            reset_evt_nxt = 1'b1; // RQ17
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            iface_r     <= scrb_pkg::SCRB_RST_SYS_MODE[7:6];
            power_r     <= scrb_pkg::SCRB_RST_SYS_MODE[5:4];
            trig_r      <= 3'h0;
            reset_evt_r <= 1'b1;
        end else begin
            iface_r     <= iface_nxt;
            power_r     <= power_nxt;
            trig_r      <= trig_nxt;
            reset_evt_r <= reset_evt_nxt;
        end
    end

    // read path and scaled threshold
    always_comb begin
        unique case (req_in.addr)
            scrb_pkg::SCRB_OFS_STATUS:     rd_mux = {8'h00, reset_evt_r, 7'h00}; // RQ17
            scrb_pkg::SCRB_OFS_FRONT_END:  rd_mux = front_r;
            scrb_pkg::SCRB_OFS_PAT_SETUP:  rd_mux = pat_setup_r;
            scrb_pkg::SCRB_OFS_PAT_CHOICE: rd_mux = pat_choice_r;
            scrb_pkg::SCRB_OFS_AT_SETUP:   rd_mux = at_setup_r;
            scrb_pkg::SCRB_OFS_AT_SCALE:   rd_mux = at_scale_r;
            scrb_pkg::SCRB_OFS_AT_OFFSET:  rd_mux = at_offset_r;
            scrb_pkg::SCRB_OFS_PROX:       rd_mux = prox_r;
            scrb_pkg::SCRB_OFS_CONTACT:    rd_mux = contact_r;
            scrb_pkg::SCRB_OFS_SYS_CMD:    rd_mux = {8'h00, iface_r, power_r, 4'h0}; // RQ18
            default:                       rd_mux = 16'h0000;
        endcase
        rvalid_nxt   = req_in.rd;
        rdata_nxt    = req_in.rd ? rd_mux : rdata_r; // RQ19
        prox_product = prox_r[7:0] * long_term_average_in;
        prox_eff_nxt = prox_product[23:8]; // RQ11
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_r    <= 16'h0000;
            rvalid_r   <= 1'b0;
            prox_eff_r <= 16'h0000;
        end else begin
            rdata_r    <= rdata_nxt;
            rvalid_r   <= rvalid_nxt;
            prox_eff_r <= prox_eff_nxt;
        end
    end

    // decoded view for the sensing core
    always_comb begin
        cfg_out.dead_time_en   = front_r[scrb_pkg::SCRB_BIT_DEAD_TIME]; // RQ1
        cfg_out.idle_state     = scrb_pkg::scrb_idle_e'(pat_setup_r[3:0]); // RQ4
        unique case (at_setup_r[2:0])
            3'h1:    cfg_out.at_mode = scrb_pkg::SCRB_AT_COMP_ONLY; // RQ7
            3'h2:    cfg_out.at_mode = scrb_pkg::SCRB_AT_FROM_COMP;
            3'h3:    cfg_out.at_mode = scrb_pkg::SCRB_AT_FROM_FINE;
            3'h4:    cfg_out.at_mode = scrb_pkg::SCRB_AT_FULL;
            default: cfg_out.at_mode = scrb_pkg::SCRB_AT_OFF;
        endcase
        cfg_out.exit_debounce  = prox_r[15:12]; // RQ9
        cfg_out.enter_debounce = prox_r[11:8]; // RQ10
        cfg_out.contact_hyst   = contact_r[15:8]; // RQ12
        cfg_out.contact_thr    = contact_r[7:0]; // RQ13
        cfg_out.iface          = scrb_pkg::scrb_iface_e'(iface_r);
        cfg_out.power          = scrb_pkg::scrb_power_e'(power_r);
    end

    assign trig_out.reseed         = trig_r[2];
    assign trig_out.retune_trigger = trig_r[1];
    assign trig_out.soft_reset     = trig_r[0];
    assign rdata_out               = rdata_r;
    assign rvalid_out              = rvalid_r;
    assign prox_thr_eff_out        = prox_eff_r;
    assign reset_event_out         = reset_evt_r;

    sequence s_cmd_write(int b);
        req_in.wr && req_in.addr == scrb_pkg::SCRB_OFS_SYS_CMD && req_in.wdata[b];
    endsequence

    sequence s_read_req;
        req_in.rd;
    endsequence

    a_dead_time_bit: assert property (@(posedge clock_in) disable iff (srst_in) // RQ1
        req_in.wr && req_in.addr == scrb_pkg::SCRB_OFS_FRONT_END && !tune_in.valid
        |=> cfg_out.dead_time_en == $past(req_in.wdata[6]))
        else $error("dead time enable does not follow bit 6");

    a_idle_state_map: assert property (@(posedge clock_in) disable iff (srst_in) // RQ4
        req_in.wr && req_in.addr == scrb_pkg::SCRB_OFS_PAT_SETUP
        |=> cfg_out.idle_state == $past(req_in.wdata[3:0]))
        else $error("idle electrode state not taken from bits 3-0");

    a_at_mode_full: assert property (@(posedge clock_in) disable iff (srst_in) // RQ7
        at_setup_r[2:0] == 3'h4 |-> cfg_out.at_mode == scrb_pkg::SCRB_AT_FULL)
        else $error("autotune code 100 not decoded as full");

    a_tune_load: assert property (@(posedge clock_in) disable iff (srst_in) // RQ8
        tune_in.valid |=> at_scale_r == $past(tune_in.scalers))
        else $error("computed scalers not loaded");

    a_debounce_fields: assert property (@(posedge clock_in) disable iff (srst_in) // RQ10
        cfg_out.enter_debounce == prox_r[11:8] && cfg_out.exit_debounce == prox_r[15:12])
        else $error("debounce fields misplaced");

    a_prox_scale: assert property (@(posedge clock_in) disable iff (srst_in) // RQ11
        $stable(prox_r) && $stable(long_term_average_in)
        |=> prox_thr_eff_out == 16'((32'($past(prox_r[7:0])) * 32'($past(long_term_average_in)))
                                    >> scrb_pkg::SCRB_PROX_SHIFT))
        else $error("scaled proximity threshold wrong");

    a_iface_reserved: assert property (@(posedge clock_in) disable iff (srst_in) // RQ14
        wr_cmd && req_in.wdata[7:6] == 2'h2 |=> $stable(iface_r))
        else $error("reserved interface code took effect");

    a_trig_pulse: assert property (@(posedge clock_in) disable iff (srst_in) // RQ16
        s_cmd_write(scrb_pkg::SCRB_BIT_RETUNE) |=> trig_out.retune_trigger
        ##1 (!trig_out.retune_trigger || $past(wr_cmd)))
        else $error("retune trigger not a single pulse");

    a_trig_zero_noop: assert property (@(posedge clock_in) disable iff (srst_in) // RQ16
        !wr_cmd |=> trig_r == 3'h0)
        else $error("trigger fired without a write");

    a_soft_rst_flag: assert property (@(posedge clock_in) disable iff (srst_in) // RQ17
        s_cmd_write(scrb_pkg::SCRB_BIT_SOFT_RST) |-> ##2 reset_event_out)
        else $error("soft reset did not raise reset event");

    a_ack_clear: assert property (@(posedge clock_in) disable iff (srst_in) // RQ18
        (s_cmd_write(scrb_pkg::SCRB_BIT_ACK_RST) and !trig_r[0]) |=> !reset_event_out)
        else $error("acknowledge did not clear reset event");

    a_read_latency: assert property (@(posedge clock_in) disable iff (srst_in) // RQ19
        (s_read_req and (req_in.addr == scrb_pkg::SCRB_OFS_CONTACT && !req_in.wr))
        |=> rvalid_out && rdata_out == contact_r)
        else $error("read did not return contact word one cycle later");

    a_contact_fields: assert property (@(posedge clock_in) disable iff (srst_in) // RQ12
        req_in.wr && req_in.addr == scrb_pkg::SCRB_OFS_CONTACT
        |=> cfg_out.contact_hyst == $past(req_in.wdata[15:8])
            && cfg_out.contact_thr == $past(req_in.wdata[7:0]))
        else $error("contact hysteresis or threshold misplaced");

    a_offset_bit_zero: assert property (@(posedge clock_in) disable iff (srst_in) // RQ8
        at_offset_r[11] == 1'b0)
        else $error("reserved offset bit stored as one");

    a_iface_take: assert property (@(posedge clock_in) disable iff (srst_in) // RQ14
        wr_cmd && req_in.wdata[7:6] != 2'h2 |=> iface_r == $past(req_in.wdata[7:6]))
        else $error("legal interface code not taken");

    a_power_take: assert property (@(posedge clock_in) disable iff (srst_in) // RQ15
        wr_cmd && req_in.wdata[5:4] != 2'h3 |=> power_r == $past(req_in.wdata[5:4]))
        else $error("legal power mode not taken");

    a_power_reserved: assert property (@(posedge clock_in) disable iff (srst_in) // RQ15
        wr_cmd && req_in.wdata[5:4] == 2'h3 |=> $stable(power_r))
        else $error("reserved power code took effect");

    a_reseed_pulse: assert property (@(posedge clock_in) disable iff (srst_in) // RQ16
        s_cmd_write(scrb_pkg::SCRB_BIT_RESEED) |=> trig_out.reseed)
        else $error("reseed trigger missing");

    a_soft_rst_pulse: assert property (@(posedge clock_in) disable iff (srst_in) // RQ16
        s_cmd_write(scrb_pkg::SCRB_BIT_SOFT_RST) |=> trig_out.soft_reset)
        else $error("soft reset trigger missing");

    a_status_read: assert property (@(posedge clock_in) disable iff (srst_in) // RQ17
        (s_read_req and req_in.addr == scrb_pkg::SCRB_OFS_STATUS)
        |=> rdata_out[7] == $past(reset_evt_r))
        else $error("status bit 7 does not show the reset event");

    a_rvalid_idle: assert property (@(posedge clock_in) disable iff (srst_in) // RQ19
        !req_in.rd |=> !rvalid_out)
        else $error("read valid without a read request");
endmodule

//--- test/scrb_host_model.sv
/*
  Host-side model of the register bank's word access: one write or read request at a time.
  Assumes the bank answers a read with rvalid one cycle after the request edge.
*/
`timescale 1ns/1ps
module scrb_host_model (
    input  wire logic           clock_in,
    input  wire logic [15:0]    rdata_in,
    input  wire logic           rvalid_in,
    output scrb_pkg::scrb_req_s req_out
);
    initial begin
        req_out = '0;
    end

    // released lines are inverted so a stale address or word can never pass as a match
    task automatic idle();
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~req_out.addr, wdata: ~req_out.wdata};
    endtask

    task automatic write(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clock_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clock_in);
        idle();
    endtask

    task automatic read(input logic [7:0] addr, output logic [15:0] data, output logic seen);
        @(posedge clock_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: req_out.wdata};
        @(posedge clock_in);
        idle();
        #1;
        seen = rvalid_in;
        data = rdata_in;
    endtask

    function automatic logic [15:0] front_end_word(input logic dead);
        return {4'h0, 1'b0, 2'b00, 2'b11, dead, 2'b00, 2'b10, 2'b11};
    endfunction

    function automatic logic [15:0] pattern_word(input logic [3:0] idle_code);
        return {4'h0, 4'hB, 4'h0, idle_code};
    endfunction

    function automatic logic [15:0] choice_word();
        return {8'h00, 8'h00};
    endfunction
endmodule

//--- test/test_scrb_bank.sv
/*
  Self-checking bench of the sensor configuration register bank.
  Assumes the host model above drives every word request and the bench drives tuning inputs.
*/
`timescale 1ns/1ps
module test_scrb_bank;
    logic                 clock_in;
    logic                 srst_in;
    scrb_pkg::scrb_req_s  req;
    scrb_pkg::scrb_tune_s tune;
    logic [15:0]          long_term_average;
    logic [15:0]          rdata;
    logic                 rvalid;
    scrb_pkg::scrb_cfg_s  cfg;
    scrb_pkg::scrb_trig_s trig;
    logic [15:0]          thr_eff;
    logic                 reset_event;
    int                   fails;
    int                   samples_checked;
    int                   cycles;
    logic [7:0]           ra [9];
    logic [15:0]          rv [9];
    logic [3:0]           idles [4];
    logic [1:0]           codes [3];

    scrb_bank i_dut (
        .clock_in             (clock_in),
        .srst_in              (srst_in),
        .req_in               (req),
        .tune_in              (tune),
        .long_term_average_in (long_term_average),
        .rdata_out            (rdata),
        .rvalid_out           (rvalid),
        .cfg_out              (cfg),
        .trig_out             (trig),
        .prox_thr_eff_out     (thr_eff),
        .reset_event_out      (reset_event)
    );

    scrb_host_model i_host (
        .clock_in  (clock_in),
        .rdata_in  (rdata),
        .rvalid_in (rvalid),
        .req_out   (req)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        i_host.read(addr, d, v);
        check({15'h0, v}, 16'h0001);
        check(d, exp);
    endtask

    // write the command word, then look at the trigger pulse and its end one cycle later
    task automatic cmd(input logic [15:0] w, input logic [2:0] exp);
        i_host.write(scrb_pkg::SCRB_OFS_SYS_CMD, w);
        #1;
        check({13'h0, trig}, {13'h0, exp});
        @(posedge clock_in);
        #1;
        check({13'h0, trig}, 16'h0000);
    endtask

    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            stop_test();
        end
    end

    initial begin
        srst_in = 1'b1;
        tune = '0;
        long_term_average = 16'h1234;
        fails = 0;
        samples_checked = 0;
        ra = '{8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h40, 8'h41, 8'h70};
        rv = '{16'h018B, 16'h0B00, 16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000,
               16'h0000, 16'h0000};
        idles = '{4'h0, 4'h5, 4'hA, 4'hF};
        codes = '{2'b00, 2'b01, 2'b11};
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd_check(ra[i], rv[i]);
        end
        rd_check(scrb_pkg::SCRB_OFS_STATUS, 16'h0080);
        rd_check(8'h55, 16'h0000);
        i_host.write(scrb_pkg::SCRB_OFS_FRONT_END, i_host.front_end_word(1'b1));
        #1;
        check({15'h0, cfg.dead_time_en}, 16'h0001);
        i_host.write(scrb_pkg::SCRB_OFS_FRONT_END, i_host.front_end_word(1'b0));
        #1;
        check({15'h0, cfg.dead_time_en}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            i_host.write(scrb_pkg::SCRB_OFS_PAT_SETUP, i_host.pattern_word(idles[i]));
            #1;
            check({12'h0, cfg.idle_state}, {12'h0, idles[i]});
        end
        i_host.write(scrb_pkg::SCRB_OFS_PAT_CHOICE, i_host.choice_word());
        rd_check(scrb_pkg::SCRB_OFS_PAT_CHOICE, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            i_host.write(scrb_pkg::SCRB_OFS_AT_SETUP, 16'(m));
            #1;
            check({13'h0, cfg.at_mode}, (m > 4) ? 16'h0000 : 16'(m));
        end
        @(posedge clock_in);
        tune <= '{valid: 1'b1, scalers: 16'hA5C3, offset: 16'hFFFF};
        @(posedge clock_in);
        tune <= '{valid: 1'b0, scalers: 16'h5A3C, offset: 16'h0000};
        rd_check(scrb_pkg::SCRB_OFS_AT_SCALE, 16'hA5C3);
        rd_check(scrb_pkg::SCRB_OFS_AT_OFFSET, 16'hF7FF);
        i_host.write(scrb_pkg::SCRB_OFS_PROX, 16'h5A80);
        #1;
        check({12'h0, cfg.exit_debounce}, 16'h0005);
        check({12'h0, cfg.enter_debounce}, 16'h000A);
        @(posedge clock_in);
        #1;
        check(thr_eff, 16'h091A);
        @(posedge clock_in);
        long_term_average <= 16'hFFFF;
        repeat (2) @(posedge clock_in);
        #1;
        check(thr_eff, 16'h7FFF);
        i_host.write(scrb_pkg::SCRB_OFS_PROX, 16'h0080);
        #1;
        check({8'h0, cfg.exit_debounce, cfg.enter_debounce}, 16'h0000);
        i_host.write(scrb_pkg::SCRB_OFS_CONTACT, 16'h1234);
        #1;
        check({8'h0, cfg.contact_hyst}, 16'h0012);
        check({8'h0, cfg.contact_thr}, 16'h0034);
        for (int i = 0; i < 3; i++) begin
            i_host.write(scrb_pkg::SCRB_OFS_SYS_CMD, {8'h00, codes[i], 6'h00});
            #1;
            check({14'h0, cfg.iface}, {14'h0, codes[i]});
        end
        i_host.write(scrb_pkg::SCRB_OFS_SYS_CMD, 16'h0080);
        #1;
        check({14'h0, cfg.iface}, 16'h0003);
        for (int p = 0; p < 4; p++) begin
            i_host.write(scrb_pkg::SCRB_OFS_SYS_CMD, {8'h00, 2'b11, 2'(p), 4'h0});
            #1;
            check({14'h0, cfg.power}, (p == 3) ? 16'h0002 : 16'(p));
        end
        rd_check(scrb_pkg::SCRB_OFS_SYS_CMD, 16'h00E0);
        cmd(16'h00E8, 3'b100);
        cmd(16'h00E4, 3'b010);
        cmd(16'h00E1, 3'b000);
        check({15'h0, reset_event}, 16'h0000);
        rd_check(scrb_pkg::SCRB_OFS_STATUS, 16'h0000);
        cmd(16'h00E2, 3'b001);
        check({15'h0, reset_event}, 16'h0001);
        rd_check(scrb_pkg::SCRB_OFS_STATUS, 16'h0080);
        stop_test();
    end
endmodule
